// >>> design/ecgcb_config_bank.sv
/*
  ECG path configuration bank: five 16-bit registers written and read
  over SPI mode 0 with burst auto-increment, their control fields driven
  out to the analog path, and the offset-binary sample encoder.
  Assumes SPI pins synchronous to clock, sclk at most a quarter of clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ecgcb_config_bank
  import ecgcb_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // SPI register port
  input  wire logic                   spi_sclk,
  input  wire logic                   spi_cs_n,
  input  wire logic                   spi_mosi,
  output var  logic                   spi_miso,
  output var  logic                   spi_miso_oe,
  // Conversion results in and offset-binary samples out
  input  wire logic [SAMPLE_BITS-1:0] conv_result,
  input  wire logic                   conv_valid,
  output var  logic [SAMPLE_BITS-1:0] sample_code,
  output var  logic                   sample_valid,
  // Analog and leg drive control
  output var  logic                   short_inverting_to_leg_drive,
  output var  logic                   short_noninverting_to_leg_drive,
  output var  logic                   prebuffer_keep_powered,
  output var  logic                   front_gain_select,
  output var  logic                   common_mode_generator_enable,
  output var  logic                   leg_drive_output_disconnect,
  output var  logic [1:0]             leg_drive_output_select,
  output var  logic                   leg_drive_lead_off_enable,
  output var  logic [1:0]             leg_drive_lead_off_threshold,
  output var  logic                   leg_drive_amp_enable,
  // Lead-off control
  output var  logic                   ac_detector_enable,
  output var  logic [2:0]             ac_excite_magnitude,
  output var  logic [2:0]             ac_detect_threshold,
  output var  logic                   low_range_dc_detector_enable,
  output var  logic [3:0]             dc_excite_magnitude,
  output var  logic                   dc_current_polarity_inverting,
  output var  logic                   dc_current_polarity_noninverting,
  output var  logic [1:0]             dc_detect_threshold,
  // Rate and decimation
  output var  logic [5:0]             decimation_ratio,
  output var  logic [2:0]             sample_rate_select,
  // Lead-off current and gain
  output var  logic                   high_range_dc_current_enable,
  output var  logic [3:0]             high_range_dc_magnitude,
  output var  logic                   dc_current_out_noninverting_enable,
  output var  logic                   dc_current_out_inverting_enable,
  output var  logic                   dc_comparator_inverting_enable,
  output var  logic                   dc_comparator_noninverting_enable,
  output var  logic                   ac_circuit_dc_mode_enable,
  output var  logic [3:0]             calibrated_gain,
  // Electrode routing
  output var  logic                   path_polarity_swap,
  output var  logic                   pads_to_impedance_path,
  output var  logic [7:0]             pad_routing_matrix
);

  // Address decode helpers
  function automatic logic is_mapped(input logic [ADDR_BITS-1:0] addr);
    is_mapped = (addr >= ADDR_ANALOG) && (addr <= ADDR_MATRIX);
  endfunction : is_mapped

  function automatic logic [2:0] reg_index(input logic [ADDR_BITS-1:0] addr);
    logic [ADDR_BITS-1:0] offset;
    offset = addr - ADDR_ANALOG;
    reg_index = offset[2:0];
  endfunction : reg_index

  function automatic logic [15:0] reg_mask(input logic [2:0] idx);
    logic [15:0] mask;
    mask = 16'h0000;
    unique case (idx)
      IDX_ANALOG:  mask = MASK_ANALOG;
      IDX_LEADOFF: mask = MASK_LEADOFF;
      IDX_RATE:    mask = MASK_RATE;
      IDX_CURRENT: mask = MASK_CURRENT;
      IDX_MATRIX:  mask = MASK_MATRIX;
      default:     mask = 16'h0000;
    endcase
    reg_mask = mask;
  endfunction : reg_mask

  // Register storage and SPI engine state
  logic [15:0]          cfg [NUM_REGS];
  ecgcb_phase_t         phase;
  logic                 sclk_prev;
  logic [3:0]           bit_count;
  logic [15:0]          shift_in;
  logic [15:0]          shift_out;
  logic [ADDR_BITS-1:0] cur_addr;

  // Edge and word decode
  wire                  sclk_rise;
  wire                  sclk_fall;
  wire                  word_done;
  wire [15:0]           next_word;
  wire                  cmd_is_write;
  wire                  write_hit;
  wire [2:0]            cur_index;
  wire [15:0]           cur_mask;
  wire [15:0]           read_word;
  wire                  load_out;
  wire [ADDR_BITS-1:0]  next_addr;

  assign sclk_rise    = !spi_cs_n && spi_sclk && !sclk_prev;
  assign sclk_fall    = !spi_cs_n && !spi_sclk && sclk_prev;
  assign word_done    = sclk_rise && (bit_count == LAST_BIT);
  assign next_word    = {shift_in[14:0], spi_mosi};
  assign cmd_is_write = next_word[CMD_RW_BIT];
  assign cur_index    = reg_index(cur_addr);
  assign cur_mask     = is_mapped(cur_addr) ? reg_mask(cur_index) : 16'h0000;
  assign write_hit    = word_done && (phase == ECGCB_WRITE) && is_mapped(cur_addr);
  assign read_word    = is_mapped(cur_addr) ? (cfg[cur_index] & cur_mask) : 16'h0000;
  assign load_out     = sclk_fall && (phase == ECGCB_READ) && (bit_count == 4'h0);
  assign next_addr    = cur_addr + 15'h0001;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= spi_sclk;
    end
  end

  // Bit and word framing; dropping chip select discards a partial word
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase     <= ECGCB_CMD;
      bit_count <= 4'h0;
      shift_in  <= 16'h0000;
      cur_addr  <= 15'h0000;
    end else if (spi_cs_n) begin
      phase     <= ECGCB_CMD;
      bit_count <= 4'h0;
    end else if (sclk_rise) begin
      shift_in  <= next_word;
      bit_count <= bit_count + 4'h1;
      if (word_done) begin
        unique case (phase)
          ECGCB_CMD: begin
            cur_addr <= next_word[15:1];
            phase    <= cmd_is_write ? ECGCB_WRITE : ECGCB_READ;
          end
          ECGCB_WRITE: begin
            cur_addr <= next_addr;
          end
          ECGCB_READ: begin
            cur_addr <= next_addr;
          end
        endcase
      end
    end
  end

  // Register writes, masked to functional bits
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg[IDX_ANALOG]  <= RST_ANALOG;
      cfg[IDX_LEADOFF] <= RST_LEADOFF;
      cfg[IDX_RATE]    <= RST_RATE;
      cfg[IDX_CURRENT] <= RST_CURRENT;
      cfg[IDX_MATRIX]  <= RST_MATRIX;
    end else if (write_hit) begin
      cfg[cur_index] <= next_word & cur_mask;
    end
  end

  // Read data out, MSB first, changing on falling sclk
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_out   <= 16'h0000;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (spi_cs_n) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (load_out) begin
      shift_out   <= read_word;
      spi_miso    <= read_word[15];
      spi_miso_oe <= 1'b1;
    end else if (sclk_fall && (phase == ECGCB_READ)) begin
      shift_out <= {shift_out[14:0], 1'b0};
      spi_miso  <= shift_out[14];
    end
  end

  // Analog and leg drive fields
  assign short_inverting_to_leg_drive    = cfg[IDX_ANALOG][POS_SHORT_INV];
  assign short_noninverting_to_leg_drive = cfg[IDX_ANALOG][POS_SHORT_NONINV];
  assign prebuffer_keep_powered          = cfg[IDX_ANALOG][POS_PREBUF_ON];
  assign front_gain_select               = cfg[IDX_ANALOG][POS_GAIN_SEL];
  assign common_mode_generator_enable    = cfg[IDX_ANALOG][POS_CM_GEN_EN];
  assign leg_drive_output_disconnect     = cfg[IDX_ANALOG][POS_LD_DISCONNECT];
  assign leg_drive_output_select         = cfg[IDX_ANALOG][POS_LD_OUT_SEL+:2];
  assign leg_drive_lead_off_enable       = cfg[IDX_ANALOG][POS_LD_LO_EN];
  assign leg_drive_lead_off_threshold    = cfg[IDX_ANALOG][POS_LD_LO_THR+:2];
  assign leg_drive_amp_enable            = cfg[IDX_ANALOG][POS_LD_AMP_EN];

  // Lead-off fields
  assign ac_detector_enable               = cfg[IDX_LEADOFF][POS_AC_EN];
  assign ac_excite_magnitude              = cfg[IDX_LEADOFF][POS_AC_MAG+:3];
  assign ac_detect_threshold              = cfg[IDX_LEADOFF][POS_AC_THR+:3];
  assign low_range_dc_detector_enable     = cfg[IDX_LEADOFF][POS_LOW_DC_EN];
  assign dc_excite_magnitude              = cfg[IDX_LEADOFF][POS_DC_MAG+:4];
  assign dc_detect_threshold              = cfg[IDX_LEADOFF][POS_DC_THR+:2];
  assign dc_current_polarity_inverting    = cfg[IDX_LEADOFF][POS_DC_POL_INV];
  assign dc_current_polarity_noninverting = cfg[IDX_LEADOFF][POS_DC_POL_NONINV];

  // Rate fields; the decimation field is left to the host
  assign decimation_ratio   = cfg[IDX_RATE][POS_DECIM+:6];
  assign sample_rate_select = cfg[IDX_RATE][POS_RATE_SEL+:3];

  // Lead-off current and gain fields
  assign high_range_dc_current_enable       = cfg[IDX_CURRENT][POS_HI_DC_EN];
  assign high_range_dc_magnitude            = cfg[IDX_CURRENT][POS_HI_DC_MAG+:4];
  assign dc_current_out_noninverting_enable = cfg[IDX_CURRENT][POS_DC_OUT_NONINV];
  assign dc_current_out_inverting_enable    = cfg[IDX_CURRENT][POS_DC_OUT_INV];
  assign dc_comparator_inverting_enable     = cfg[IDX_CURRENT][POS_DC_CMP_INV];
  assign dc_comparator_noninverting_enable  = cfg[IDX_CURRENT][POS_DC_CMP_NONINV];
  assign ac_circuit_dc_mode_enable          = cfg[IDX_CURRENT][POS_AC_DC_MODE];
  assign calibrated_gain                    = cfg[IDX_CURRENT][POS_CAL_GAIN+:4];

  // Routing fields
  assign path_polarity_swap     = cfg[IDX_MATRIX][POS_POL_SWAP];
  assign pads_to_impedance_path = cfg[IDX_MATRIX][POS_TO_IMPEDANCE];
  assign pad_routing_matrix     = cfg[IDX_MATRIX][POS_PAD_MATRIX+:8];

  // Sample coding
  ecgcb_sample_encoder u_encoder (
    .clock        (clock),
    .resetn       (resetn),
    .conv_result  (conv_result),
    .conv_valid   (conv_valid),
    .sample_code  (sample_code),
    .sample_valid (sample_valid)
  );

endmodule : ecgcb_config_bank
`default_nettype wire

// >>> design/ecgcb_pkg.sv
/*
  Constants for the ECG path configuration bank: register addresses,
  writable masks, reset values, field positions and SPI framing.
  Assumes a 15-bit register address space reached over SPI.
*/
`default_nettype none
package ecgcb_pkg;
  // SPI framing
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 15;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam int CMD_RW_BIT = 0;
  localparam int SAMPLE_BITS = 24;
  localparam logic [23:0] CENTER_CODE = 24'h800000;
  // Register addresses
  localparam logic [14:0] ADDR_ANALOG = 15'h0100;
  localparam logic [14:0] ADDR_LEADOFF = 15'h0101;
  localparam logic [14:0] ADDR_RATE = 15'h0102;
  localparam logic [14:0] ADDR_CURRENT = 15'h0103;
  localparam logic [14:0] ADDR_MATRIX = 15'h0104;
  localparam int NUM_REGS = 5;
  localparam logic [2:0] IDX_ANALOG = 3'h0;
  localparam logic [2:0] IDX_LEADOFF = 3'h1;
  localparam logic [2:0] IDX_RATE = 3'h2;
  localparam logic [2:0] IDX_CURRENT = 3'h3;
  localparam logic [2:0] IDX_MATRIX = 3'h4;
  // Bits that hold a function
  localparam logic [15:0] MASK_ANALOG = 16'h1BFF;
  localparam logic [15:0] MASK_LEADOFF = 16'hFFFF;
  localparam logic [15:0] MASK_RATE = 16'h01FF;
  localparam logic [15:0] MASK_CURRENT = 16'hFFCF;
  localparam logic [15:0] MASK_MATRIX = 16'h03FF;
  // Reset values
  localparam logic [15:0] RST_ANALOG = 16'h0000;
  localparam logic [15:0] RST_LEADOFF = 16'h0000;
  localparam logic [15:0] RST_RATE = 16'h0000;
  localparam logic [15:0] RST_CURRENT = 16'h0000;
  localparam logic [15:0] RST_MATRIX = 16'h0000;
  // Analog and leg drive control fields
  localparam int POS_SHORT_INV = 12;
  localparam int POS_SHORT_NONINV = 11;
  localparam int POS_PREBUF_ON = 9;
  localparam int POS_GAIN_SEL = 8;
  localparam int POS_CM_GEN_EN = 7;
  localparam int POS_LD_DISCONNECT = 6;
  localparam int POS_LD_OUT_SEL = 4;
  localparam int POS_LD_LO_EN = 3;
  localparam int POS_LD_LO_THR = 1;
  localparam int POS_LD_AMP_EN = 0;
  // Lead-off control fields
  localparam int POS_AC_EN = 15;
  localparam int POS_AC_MAG = 12;
  localparam int POS_AC_THR = 9;
  localparam int POS_LOW_DC_EN = 8;
  localparam int POS_DC_MAG = 4;
  localparam int POS_DC_POL_INV = 3;
  localparam int POS_DC_POL_NONINV = 2;
  localparam int POS_DC_THR = 0;
  // Rate and decimation fields
  localparam int POS_DECIM = 3;
  localparam int POS_RATE_SEL = 0;
  // Lead-off current and gain fields
  localparam int POS_HI_DC_EN = 15;
  localparam int POS_HI_DC_MAG = 11;
  localparam int POS_DC_OUT_NONINV = 10;
  localparam int POS_DC_OUT_INV = 9;
  localparam int POS_DC_CMP_INV = 8;
  localparam int POS_DC_CMP_NONINV = 7;
  localparam int POS_AC_DC_MODE = 6;
  localparam int POS_CAL_GAIN = 0;
  // Routing matrix fields
  localparam int POS_POL_SWAP = 9;
  localparam int POS_TO_IMPEDANCE = 8;
  localparam int POS_PAD_MATRIX = 0;
  // SPI engine phases
  typedef enum logic [1:0] {
    ECGCB_CMD,
    ECGCB_WRITE,
    ECGCB_READ
  } ecgcb_phase_t;
endpackage : ecgcb_pkg
`default_nettype wire

// >>> design/ecgcb_sample_encoder.sv
/*
  Offset-binary encoder for ECG conversion results.
  Assumes a two's-complement result of input voltage over resolution.
*/
`timescale 1ns/1ps
`default_nettype none
module ecgcb_sample_encoder
  import ecgcb_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // Signed conversion result
  input  wire logic [SAMPLE_BITS-1:0] conv_result,
  input  wire logic                   conv_valid,
  // Offset-binary sample
  output var  logic [SAMPLE_BITS-1:0] sample_code,
  output var  logic                   sample_valid
);
  logic [SAMPLE_BITS-1:0] next_code;

  assign next_code = conv_result + CENTER_CODE;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sample_code  <= 24'h000000;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= conv_valid;
      if (conv_valid) begin
        sample_code <= next_code;
      end
    end
  end
endmodule : ecgcb_sample_encoder
`default_nettype wire

// >>> test/ecgcb_host.sv
/* Host SPI model, mode 0, driven by tasks.
   Assumes clock is the device clock; sclk phases 3 low, 2 high. */
`timescale 1ns/1ps
`default_nettype none
module ecgcb_host (
  // Clock
  input  wire logic clock,
  // SPI
  input  wire logic spi_miso,
  output var  logic spi_sclk,
  output var  logic spi_cs_n,
  output var  logic spi_mosi
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic select_dev();
    @(posedge clock);
    spi_cs_n <= 1'b0;
  endtask : select_dev
  // Gap of 3 clocks on each side of release
  task automatic release_dev();
    repeat (3) @(posedge clock);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    repeat (3) @(posedge clock);
  endtask : release_dev
  // Top n bits of w, MSB first; miso taken at each rise
  task automatic shift(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    for (int i = 15; i > 15 - n; i--) begin
      spi_mosi <= w[i];
      repeat (3) @(posedge clock);
      r[i] = spi_miso;
      spi_sclk <= 1'b1;
      repeat (2) @(posedge clock);
      spi_sclk <= 1'b0;
    end
  endtask : shift
endmodule : ecgcb_host
`default_nettype wire

// >>> test/ecgcb_monitor.sv
/* Checker on the config bank ports.
   Assumes bind to ecgcb_config_bank and cs_n high through reset. */
`timescale 1ns/1ps
`default_nettype none
module ecgcb_monitor
  import ecgcb_pkg::*;
(
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   resetn,
  // SPI and samples
  input wire logic                   spi_cs_n,
  input wire logic                   spi_miso,
  input wire logic                   spi_miso_oe,
  input wire logic [SAMPLE_BITS-1:0] conv_result,
  input wire logic                   conv_valid,
  input wire logic [SAMPLE_BITS-1:0] sample_code,
  input wire logic                   sample_valid,
  // Config fields
  input wire logic                   front_gain_select,
  input wire logic [1:0]             leg_drive_output_select,
  input wire logic [2:0]             ac_excite_magnitude,
  input wire logic [3:0]             dc_excite_magnitude,
  input wire logic [2:0]             sample_rate_select,
  input wire logic [3:0]             calibrated_gain,
  input wire logic [7:0]             pad_routing_matrix
);
  logic [1:0] cs_q;
  wire  logic idle;
  assign idle = spi_cs_n & (&cs_q);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      cs_q <= 2'h3;
    else
      cs_q <= {cs_q[0], spi_cs_n};
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_sample;
    conv_valid |=> sample_valid && sample_code == $past(conv_result) + CENTER_CODE;
  endproperty
  a_sample: assert property (p_sample) else $error("sample code wrong");
  property p_no_sample;
    !conv_valid |=> !sample_valid;
  endproperty
  a_no_sample: assert property (p_no_sample) else $error("stray sample valid");
  property p_miso_idle;
    idle |-> !spi_miso_oe && !spi_miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven while idle");
  property p_analog;
    idle |=> $stable({front_gain_select, leg_drive_output_select});
  endproperty
  a_analog: assert property (p_analog) else $error("analog fields moved while idle");
  property p_leadoff;
    idle |=> $stable({ac_excite_magnitude, dc_excite_magnitude});
  endproperty
  a_leadoff: assert property (p_leadoff) else $error("lead-off fields moved while idle");
  property p_rate;
    idle |=> $stable(sample_rate_select);
  endproperty
  a_rate: assert property (p_rate) else $error("rate field moved while idle");
  property p_current;
    idle |=> $stable(calibrated_gain);
  endproperty
  a_current: assert property (p_current) else $error("gain field moved while idle");
  property p_matrix;
    idle |=> $stable(pad_routing_matrix);
  endproperty
  a_matrix: assert property (p_matrix) else $error("matrix moved while idle");
endmodule : ecgcb_monitor
bind ecgcb_config_bank ecgcb_monitor i_mon (.clock, .resetn, .spi_cs_n, .spi_miso, .spi_miso_oe, .conv_result,
  .conv_valid, .sample_code, .sample_valid, .front_gain_select, .leg_drive_output_select, .ac_excite_magnitude,
  .dc_excite_magnitude, .sample_rate_select, .calibrated_gain, .pad_routing_matrix);
`default_nettype wire

// >>> test/tb.sv
/* Self-checking bench for ecgcb_config_bank.
   Assumes ecgcb_host drives SPI and ecgcb_monitor is bound. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ecgcb_pkg::*;
  localparam logic [15:0] MASKS [5] = '{MASK_ANALOG, MASK_LEADOFF, MASK_RATE, MASK_CURRENT, MASK_MATRIX};
  logic                   clock = 1'b0;
  logic                   resetn = 1'b0;
  logic [SAMPLE_BITS-1:0] conv_result = '0;
  logic                   conv_valid = 1'b0;
  logic [15:0]            exp_reg [5];
  int                     n_errors = 0;
  int                     checked = 0;
  wire logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, sample_valid;
  wire logic [SAMPLE_BITS-1:0] sample_code;
  wire logic short_inverting_to_leg_drive, short_noninverting_to_leg_drive, prebuffer_keep_powered;
  wire logic front_gain_select, common_mode_generator_enable, leg_drive_output_disconnect;
  wire logic leg_drive_lead_off_enable, leg_drive_amp_enable, ac_detector_enable, low_range_dc_detector_enable;
  wire logic dc_current_polarity_inverting, dc_current_polarity_noninverting, high_range_dc_current_enable;
  wire logic dc_current_out_noninverting_enable, dc_current_out_inverting_enable, ac_circuit_dc_mode_enable;
  wire logic dc_comparator_inverting_enable, dc_comparator_noninverting_enable, path_polarity_swap;
  wire logic pads_to_impedance_path;
  wire logic [1:0] leg_drive_output_select, leg_drive_lead_off_threshold, dc_detect_threshold;
  wire logic [2:0] ac_excite_magnitude, ac_detect_threshold, sample_rate_select;
  wire logic [3:0] dc_excite_magnitude, high_range_dc_magnitude, calibrated_gain;
  wire logic [5:0] decimation_ratio;
  wire logic [7:0] pad_routing_matrix;
  always #5 clock = ~clock;
  ecgcb_config_bank i_dut (.*);
  // Undriven miso reads high, so read data only counts while the enable stands
  ecgcb_host i_host (.clock(clock), .spi_miso(spi_miso_oe ? spi_miso : 1'b1), .spi_sclk(spi_sclk),
                     .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
  // Registers rebuilt from the field outputs
  function automatic logic [15:0] seen(input int k);
    case (k)
      0: return {3'h0, short_inverting_to_leg_drive, short_noninverting_to_leg_drive, 1'b0, prebuffer_keep_powered,
                 front_gain_select, common_mode_generator_enable, leg_drive_output_disconnect, leg_drive_output_select,
                 leg_drive_lead_off_enable, leg_drive_lead_off_threshold, leg_drive_amp_enable};
      1: return {ac_detector_enable, ac_excite_magnitude, ac_detect_threshold, low_range_dc_detector_enable,
                 dc_excite_magnitude, dc_current_polarity_inverting, dc_current_polarity_noninverting, dc_detect_threshold};
      2: return {7'h00, decimation_ratio, sample_rate_select};
      3: return {high_range_dc_current_enable, high_range_dc_magnitude, dc_current_out_noninverting_enable,
                 dc_current_out_inverting_enable, dc_comparator_inverting_enable, dc_comparator_noninverting_enable,
                 ac_circuit_dc_mode_enable, 2'h0, calibrated_gain};
      default: return {6'h00, path_polarity_swap, pads_to_impedance_path, pad_routing_matrix};
    endcase
  endfunction : seen
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, want, got);
    end
  endtask : chk
  task automatic xfer(input logic [14:0] a, input logic rw, input int n, inout logic [15:0] d [5]);
    logic [15:0] r;
    i_host.select_dev();
    i_host.shift({a, rw}, 16, r);
    for (int k = 0; k < n; k++) begin
      i_host.shift(rw ? d[k] : 16'hC33C, 16, r);
      if (!rw) d[k] = r;
    end
    i_host.release_dev();
  endtask : xfer
  task automatic check_all();
    logic [15:0] d [5];
    xfer(ADDR_ANALOG, 1'b0, 5, d);
    for (int k = 0; k < 5; k++) begin
      chk("readback", d[k], exp_reg[k]);
      chk("fields", seen(k), exp_reg[k]);
    end
  endtask : check_all
  task automatic t_fields();
    logic [15:0] pats [4] = '{16'hFFFF, 16'h5AA5, 16'hA55A, 16'h0000};
    logic [15:0] d [5];
    foreach (pats[p]) begin
      for (int k = 0; k < 5; k++) begin
        d[k] = (k == 2) ? (pats[p] & ~16'h01F8) : pats[p];
        exp_reg[k] = d[k] & MASKS[k];
      end
      xfer(ADDR_ANALOG, 1'b1, 5, d);
      check_all();
    end
    $display("fields test done");
  endtask : t_fields
  task automatic t_edges();
    logic [15:0] d [5] = '{16'h1234, 16'hC3C3, 16'h0000, 16'h0000, 16'h0000};
    xfer(ADDR_ANALOG - 15'h0001, 1'b1, 2, d);
    exp_reg[0] = 16'hC3C3 & MASKS[0];
    d[0] = 16'hFFFF;
    xfer(ADDR_MATRIX + 15'h0001, 1'b1, 1, d);
    xfer(ADDR_MATRIX + 15'h0001, 1'b0, 1, d);
    chk("unmapped read", d[0], 16'h0000);
    check_all();
    $display("address edge test done");
  endtask : t_edges
  task automatic t_partial();
    logic [15:0] r;
    i_host.select_dev();
    i_host.shift({ADDR_CURRENT, 1'b1}, 16, r);
    i_host.shift(16'hFFFF, 16, r);
    i_host.shift(16'hFFFF, 15, r);
    i_host.release_dev();
    exp_reg[3] = MASKS[3];
    check_all();
    $display("partial word test done");
  endtask : t_partial
  task automatic t_sample();
    logic [23:0] vin [4] = '{24'h000000, 24'hFFFFFF, 24'h800000, 24'h7FFFFF};
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      conv_valid <= (i < 4);
      conv_result <= (i < 4) ? vin[i] : 24'h5A5A5A;
      @(negedge clock);
      chk("sample valid", sample_valid, (i > 0 && i < 5));
      if (i > 0 && i < 5) chk("sample code", sample_code, 24'(vin[i-1] + CENTER_CODE));
    end
    $display("sample test done");
  endtask : t_sample
  task automatic t_reset();
    @(posedge clock);
    resetn <= 1'b0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    exp_reg = '{RST_ANALOG, RST_LEADOFF, RST_RATE, RST_CURRENT, RST_MATRIX};
    chk("reset code", sample_code, 24'h000000);
    check_all();
    $display("reset test done");
  endtask : t_reset
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    t_reset();
    t_fields();
    t_edges();
    t_partial();
    t_sample();
    t_reset();
    finish_test();
  end
  initial begin
    #400us;
    n_errors++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
